// File: hdl/gpxp_cfg.svh
// Purpose: constants for the two-bank i2c gpio expander
// Assumes: included by bare name from the design files
// Notes: bank count and byte width are fixed by the wire protocol
`ifndef GPXP_CFG_SVH
`define GPXP_CFG_SVH

// command pointer encoding: bits [2:1] category, bit 0 bank
`define GPXP_CMD_W 3
`define GPXP_CMD_RESET 3'h0
`define GPXP_CAT_INPUT 2'h0
`define GPXP_CAT_OUTPUT 2'h1
`define GPXP_CAT_INVERT 2'h2
`define GPXP_CAT_DIR 2'h3
`define GPXP_CMD_CAT_HI 2
`define GPXP_CMD_CAT_LO 1
`define GPXP_CMD_BANK 0

// register map byte offsets
`define GPXP_OFS_INPUT0 8'h00
`define GPXP_OFS_INPUT1 8'h01
`define GPXP_OFS_OUTPUT0 8'h02
`define GPXP_OFS_OUTPUT1 8'h03
`define GPXP_OFS_INVERT0 8'h04
`define GPXP_OFS_INVERT1 8'h05
`define GPXP_OFS_DIR0 8'h06
`define GPXP_OFS_DIR1 8'h07

// reset values
`define GPXP_RST_OUTPUT 8'hFF
`define GPXP_RST_INVERT 8'h00
`define GPXP_RST_DIR 8'hFF

// byte framing
`define GPXP_BITS_PER_BYTE 4'h8
`define GPXP_MSB 7
`define GPXP_DIR_READ 1'b1

// arbitrary default slave address, not tied to any product
`define GPXP_DEF_ADDR 7'h20

`endif

// File: hdl/gpxp_pkg.sv
// Purpose: shared types of the two-bank i2c gpio expander
// Assumes: constants live in gpxp_cfg.svh
// Notes: types only
package gpxp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } gpxp_state_t;

    // pin drive bundle toward the pads
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] oe;
    } gpxp_drive_t;

endpackage

// File: hdl/gpxp_expander.sv
// Purpose: i2c slave gpio expander, two 8-bit totem-pole banks
// Assumes: clk_sys 100 MHz, far faster than scl; srst synchronous high
// Notes: scl, sda and port pins pass two flops before any logic
// Overview of operation
// - first byte after start holds 7-bit address; bit 0 zero means write.
// - second written byte loads the command pointer selecting the register.
// - data bit 0 is lowest bank pin; first byte to the commanded bank, second to the other.
// - after each data byte the pointer toggles to the other bank.
// - bytes written to input registers are acknowledged and discarded.
// - written output levels reach output pins during the following acknowledge.
// - extra data bytes keep being stored, overwriting earlier values.
// - a stop condition ends any transfer and returns to idle.
// - commands 0-7 select input, output, invert, direction, banks 0 and 1.
// - reset clears the command pointer to the first input register.
// - output, invert and direction reads return last written or reset values.
// - input register reads return the present pin levels, inputs or outputs.
// - reading past two bytes keeps returning registers, toggling banks.
// - pins are sampled at the acknowledge; short glitches may be missed.
// - interrupt goes low when an input-configured pin changes state.
// - interrupt is not latched; it clears when the pin returns.
// - interrupt stays low until every changed input bank has been read.
// - input changes during a read leave the interrupt asserted afterwards.
// - direction bit zero drives the pin, one makes it an input.
// - invert bit one inverts the returned input level, zero passes it.
// - output bit sets the level of output pins; ignored for inputs.
`include "gpxp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module gpxp_expander #(
    parameter logic [6:0] SLAVE_ADDR = `GPXP_DEF_ADDR
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // i2c bus, sda open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // port pins
    input wire logic [15:0] gpio_in,
    output gpxp_pkg::gpxp_drive_t gpio_drv,
    // change interrupt, active low
    output logic int_n
);

    function automatic logic [1:0] cmd_cat(input logic [2:0] cmd);
        cmd_cat = cmd[`GPXP_CMD_CAT_HI:`GPXP_CMD_CAT_LO];
    endfunction

    function automatic logic cmd_bank(input logic [2:0] cmd);
        cmd_bank = cmd[`GPXP_CMD_BANK];
    endfunction

    // synchronisers
    logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
    logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
    logic [15:0] pin_meta_ff, pin_sync_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_in;
            scl_sync_ff <= scl_meta_ff;
            scl_prev_ff <= scl_sync_ff;
            sda_meta_ff <= sda_in;
            sda_sync_ff <= sda_meta_ff;
            sda_prev_ff <= sda_sync_ff;
        end
    end

    // pins keep sampling through reset so the first reference is real;
    // flushing them to zero would raise a false change at release
    always_ff @(posedge clk_sys) begin
        pin_meta_ff <= gpio_in;
        pin_sync_ff <= pin_meta_ff;
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_sync_ff & ~scl_prev_ff;
    assign scl_fall = ~scl_sync_ff & scl_prev_ff;
    assign start_det = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
    assign stop_det = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

    // register file
    logic [7:0] out_ff [2];
    logic [7:0] inv_ff [2];
    logic [7:0] dir_ff [2];
    logic [15:0] ref_ff;
    logic ref_valid_ff;

    gpxp_pkg::gpxp_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic [7:0] snap_ff;
    logic rw_ff;
    logic acked_ff;
    logic sda_oe_ff;
    logic [2:0] ptr_ff;
    logic int_n_ff;

    logic byte_end, addr_hit, wr_pulse, rd_load, rd_done;
    logic [7:0] pin_bank, rd_byte;
    logic [1:0] ptr_cat;
    logic ptr_bank;

    assign byte_end = scl_fall && (bit_cnt_ff == `GPXP_BITS_PER_BYTE);
    assign addr_hit = (shift_ff[7:1] == SLAVE_ADDR);
    assign ptr_cat = cmd_cat(ptr_ff);
    assign ptr_bank = cmd_bank(ptr_ff);
    // data byte ends at the falling edge that opens its acknowledge
    assign wr_pulse = (state_ff == gpxp_pkg::ST_WDATA) && byte_end;
    // next read byte is taken on the falling edge that ends an ack bit
    assign rd_load = scl_fall &&
        (((state_ff == gpxp_pkg::ST_ADDR_ACK) && rw_ff) ||
         ((state_ff == gpxp_pkg::ST_RACK) && acked_ff));
    assign rd_done = (state_ff == gpxp_pkg::ST_RACK) && scl_rise;

    // current pin levels of the selected bank, inputs and outputs alike
    assign pin_bank = ptr_bank ? pin_sync_ff[15:8] : pin_sync_ff[7:0];

    always_comb begin
        unique case (ptr_cat)
            `GPXP_CAT_INPUT: rd_byte = pin_bank ^ inv_ff[ptr_bank];
            `GPXP_CAT_OUTPUT: rd_byte = out_ff[ptr_bank];
            `GPXP_CAT_INVERT: rd_byte = inv_ff[ptr_bank];
            `GPXP_CAT_DIR: rd_byte = dir_ff[ptr_bank];
        endcase
    end

    // protocol sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff <= gpxp_pkg::ST_IDLE;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            tx_ff <= '0;
            rw_ff <= 1'b0;
            acked_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (stop_det) begin
            state_ff <= gpxp_pkg::ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (start_det) begin
            // repeated start lands here too, pointer kept
            state_ff <= gpxp_pkg::ST_ADDR;
            bit_cnt_ff <= '0;
            sda_oe_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                gpxp_pkg::ST_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                gpxp_pkg::ST_ADDR,
                gpxp_pkg::ST_CMD,
                gpxp_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_sync_ff};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (byte_end) begin
                        bit_cnt_ff <= '0;
                        sda_oe_ff <= 1'b1;
                        if (state_ff == gpxp_pkg::ST_ADDR) begin
                            rw_ff <= shift_ff[0];
                            sda_oe_ff <= addr_hit;
                            state_ff <= addr_hit ? gpxp_pkg::ST_ADDR_ACK
                                                 : gpxp_pkg::ST_IDLE;
                        end else if (state_ff == gpxp_pkg::ST_CMD) begin
                            state_ff <= gpxp_pkg::ST_CMD_ACK;
                        end else begin
                            // input bank bytes are still acknowledged
                            state_ff <= gpxp_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                gpxp_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff == `GPXP_DIR_READ) begin
                            state_ff <= gpxp_pkg::ST_RDATA;
                            tx_ff <= rd_byte;
                            sda_oe_ff <= ~rd_byte[`GPXP_MSB];
                            bit_cnt_ff <= 4'h1;
                        end else begin
                            state_ff <= gpxp_pkg::ST_CMD;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                gpxp_pkg::ST_CMD_ACK,
                gpxp_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_ff <= gpxp_pkg::ST_WDATA;
                        sda_oe_ff <= 1'b0;
                    end
                end
                gpxp_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == `GPXP_BITS_PER_BYTE) begin
                            state_ff <= gpxp_pkg::ST_RACK;
                            sda_oe_ff <= 1'b0;
                        end else begin
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            sda_oe_ff <= ~tx_ff[`GPXP_MSB - 1];
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                gpxp_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        acked_ff <= ~sda_sync_ff;
                    end
                    if (scl_fall) begin
                        if (acked_ff) begin
                            state_ff <= gpxp_pkg::ST_RDATA;
                            tx_ff <= rd_byte;
                            sda_oe_ff <= ~rd_byte[`GPXP_MSB];
                            bit_cnt_ff <= 4'h1;
                        end else begin
                            // no ack: wait for the master's stop
                            state_ff <= gpxp_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // command pointer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr_ff <= `GPXP_CMD_RESET;
        end else if ((state_ff == gpxp_pkg::ST_CMD) && byte_end) begin
            // upper command bits are not decoded
            ptr_ff <= shift_ff[`GPXP_CMD_W-1:0];
        end else if (wr_pulse || rd_done) begin
            ptr_ff[`GPXP_CMD_BANK] <= ~ptr_ff[`GPXP_CMD_BANK];
        end
    end

    // register writes land as the ack phase opens
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int b = 0; b < 2; b++) begin
                out_ff[b] <= `GPXP_RST_OUTPUT;
                inv_ff[b] <= `GPXP_RST_INVERT;
                dir_ff[b] <= `GPXP_RST_DIR;
            end
        end else if (wr_pulse) begin
            unique case (ptr_cat)
                `GPXP_CAT_INPUT: ;
                `GPXP_CAT_OUTPUT: out_ff[ptr_bank] <= shift_ff;
                `GPXP_CAT_INVERT: inv_ff[ptr_bank] <= shift_ff;
                `GPXP_CAT_DIR: dir_ff[ptr_bank] <= shift_ff;
            endcase
        end
    end

    // snapshot of the raw bank at the ack, committed once the byte is out
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            snap_ff <= '0;
        end else if (rd_load) begin
            snap_ff <= pin_bank;
        end
    end

    // reference levels start from the pins seen just after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ref_ff <= '0;
            ref_valid_ff <= 1'b0;
        end else if (!ref_valid_ff) begin
            ref_ff <= pin_sync_ff;
            ref_valid_ff <= 1'b1;
        end else if (rd_done && (ptr_cat == `GPXP_CAT_INPUT)) begin
            if (ptr_bank) begin
                ref_ff[15:8] <= snap_ff;
            end else begin
                ref_ff[7:0] <= snap_ff;
            end
        end
    end

    // level compare, not a latch: a reverting pin clears it by itself;
    // a change after the snapshot keeps differing from the new reference
    logic [15:0] dir_all;
    assign dir_all = {dir_ff[1], dir_ff[0]};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            int_n_ff <= 1'b1;
        end else begin
            int_n_ff <= ~(ref_valid_ff &&
                |((pin_sync_ff ^ ref_ff) & dir_all));
        end
    end

    // pad drive
    gpxp_pkg::gpxp_drive_t drv_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            drv_ff.level <= {`GPXP_RST_OUTPUT, `GPXP_RST_OUTPUT};
            drv_ff.oe <= '0;
        end else begin
            drv_ff.level <= {out_ff[1], out_ff[0]};
            drv_ff.oe <= ~dir_all;
        end
    end

    assign gpio_drv = drv_ff;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign int_n = int_n_ff;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    AST_STOP_IDLE: assert property (
        stop_det |=> (state_ff == gpxp_pkg::ST_IDLE) && !sda_oe_ff)
        else $error("stop did not return to idle");

    AST_PTR_RESET: assert property (
        $past(srst) |-> (ptr_ff == `GPXP_CMD_RESET))
        else $error("pointer not cleared by reset");

    AST_PTR_TOGGLE: assert property (
        (wr_pulse && !stop_det && !start_det) |=>
            (ptr_ff[0] != $past(ptr_ff[0])) &&
            (ptr_ff[2:1] == $past(ptr_ff[2:1])))
        else $error("pointer did not toggle bank");

    AST_INPUT_DISCARD: assert property (
        (wr_pulse && (ptr_cat == `GPXP_CAT_INPUT)) |=>
            ($stable(out_ff[0]) && $stable(out_ff[1]) &&
             $stable(dir_ff[0]) && $stable(dir_ff[1]) &&
             $stable(inv_ff[0]) && $stable(inv_ff[1]) && sda_oe_ff))
        else $error("input write changed state or was not acked");

    AST_OUT_WRITE: assert property (
        (wr_pulse && (ptr_cat == `GPXP_CAT_OUTPUT) && !ptr_bank) |=>
            ##1 (gpio_drv.level[7:0] == $past(shift_ff, 2)))
        else $error("output level not updated at ack");

    AST_OE_DIR: assert property (
        ##1 (gpio_drv.oe == ~$past(dir_all)))
        else $error("pin drive does not follow direction");

    AST_ADDR_ACK: assert property (
        ((state_ff == gpxp_pkg::ST_ADDR) && byte_end && addr_hit &&
         !stop_det && !start_det) |=>
            sda_oe_ff && (state_ff == gpxp_pkg::ST_ADDR_ACK))
        else $error("matching address not acknowledged");

    AST_ADDR_MISS: assert property (
        ((state_ff == gpxp_pkg::ST_ADDR) && byte_end && !addr_hit &&
         !stop_det && !start_det) |=>
            !sda_oe_ff && (state_ff == gpxp_pkg::ST_IDLE))
        else $error("foreign address acknowledged");

    AST_CMD_LOAD: assert property (
        ((state_ff == gpxp_pkg::ST_CMD) && byte_end &&
         !stop_det && !start_det) |=>
            (ptr_ff == $past(shift_ff[2:0])))
        else $error("command byte not loaded");

    AST_INT_OUTPUT_ONLY: assert property (
        (ref_valid_ff && (dir_all == '0)) |=> int_n_ff)
        else $error("interrupt from output pins");

    AST_INT_RAISE: assert property (
        (ref_valid_ff && |((pin_sync_ff ^ ref_ff) & dir_all)) |=> !int_n_ff)
        else $error("input change did not assert interrupt");

    AST_REF_COMMIT: assert property (
        (rd_done && ref_valid_ff && (ptr_cat == `GPXP_CAT_INPUT) &&
         !ptr_bank) |=> (ref_ff[7:0] == $past(snap_ff)))
        else $error("reference not updated on read");

    AST_READ_LOAD: assert property (
        (rd_load && !stop_det && !start_det) |=>
            (tx_ff == $past(rd_byte)) && (state_ff == gpxp_pkg::ST_RDATA))
        else $error("read byte not loaded");

endmodule

`default_nettype wire

// File: sim/gpxp_i2c_master.sv
// Purpose: behavioural i2c bus master facing the expander
// Assumes: sda has a pull-up; scl half period is HALF clk_sys cycles
// Notes: bus lines change only just after clk_sys rising edges
`include "gpxp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module gpxp_i2c_master #(
    parameter int HALF = 20
) (
    // clock
    input wire logic clk_sys,
    // resolved data line
    input wire logic sda_wire,
    // bus drive, sda_pull high pulls sda low
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // also serves as repeated start when scl is low
    task automatic start;
        sda_pull <= 1'b0;
        tick(HALF / 2);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b1;
        tick(HALF / 2);
        scl <= 1'b0;
        tick(HALF / 2);
    endtask

    task automatic stop;
        sda_pull <= 1'b1;
        tick(HALF / 2);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b0;
        tick(HALF);
    endtask

    // sample at the end of scl high, where the slave's bit is settled
    task automatic bit_io(input logic b, output logic s);
        sda_pull <= ~b;
        tick(HALF / 2);
        scl <= 1'b1;
        tick(HALF);
        s = sda_wire;
        scl <= 1'b0;
        tick(HALF / 2);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d [3],
                      input int n, output int nak);
        logic a;
        nak = 0;
        start();
        send({`GPXP_DEF_ADDR, 1'b0}, a);
        nak += int'(!a);
        send(cmd, a);
        nak += int'(!a);
        for (int i = 0; i < n; i++) begin
            send(d[i], a);
            nak += int'(!a);
        end
        stop();
    endtask

    // a negative cmd reads from the current pointer
    task automatic rd(input int cmd, input int n, output logic [7:0] q [3],
                      output int nak);
        logic a;
        nak = 0;
        start();
        if (cmd >= 0) begin
            send({`GPXP_DEF_ADDR, 1'b0}, a);
            nak += int'(!a);
            send(8'(cmd), a);
            nak += int'(!a);
            start();
        end
        send({`GPXP_DEF_ADDR, `GPXP_DIR_READ}, a);
        nak += int'(!a);
        for (int i = 0; i < n; i++) begin
            recv(i < n - 1, q[i]);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the two-bank i2c gpio expander
// Assumes: master model gpxp_i2c_master; scl slowed to suit the sync
// Notes: a pad shows the drive level where enabled, else ext
`include "gpxp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk_sys;
    logic srst;
    logic scl;
    logic sda_pull;
    logic sda_oe;
    logic sda_out;
    logic int_n;
    logic [15:0] ext;
    gpxp_pkg::gpxp_drive_t gpio_drv;
    wire logic sda_wire;
    wire logic [15:0] gpio_in;
    int errors;
    int num_checks;

    assign sda_wire = ~(sda_oe | sda_pull);
    assign gpio_in = (gpio_drv.oe & gpio_drv.level) | (~gpio_drv.oe & ext);

    gpxp_expander u_dut (.clk_sys(clk_sys), .srst(srst), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .gpio_in(gpio_in),
        .gpio_drv(gpio_drv), .int_n(int_n));
    gpxp_i2c_master #(.HALF(20)) u_mst (.clk_sys(clk_sys),
        .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wait_int(input logic v);
        int n;
        n = 0;
        while (int_n !== v && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk({15'h0, int_n}, {15'h0, v}, "int_n level");
        if (int_n !== v) end_of_test();
    endtask

    task automatic rd16(input int cmd, output logic [15:0] v);
        logic [7:0] q [3];
        int nak;
        u_mst.rd(cmd, 2, q, nak);
        chk(16'(nak), 16'h0000, "read not acked");
        v = {q[1], q[0]};
    endtask

    task automatic wr16(input logic [7:0] cmd, input logic [15:0] v);
        int nak;
        u_mst.wr(cmd, '{v[7:0], v[15:8], 8'h00}, 2, nak);
        chk(16'(nak), 16'h0000, "write not acked");
    endtask

    task automatic sc_reset;
        logic [15:0] v;
        logic [15:0] rst [4];
        rst = '{16'h0000, {2{`GPXP_RST_OUTPUT}}, {2{`GPXP_RST_INVERT}},
                {2{`GPXP_RST_DIR}}};
        chk(gpio_drv.oe, 16'h0000, "oe after reset");
        chk({15'h0, int_n}, 16'h0001, "int after reset");
        chk({15'h0, sda_out}, 16'h0000, "sda drive value");
        rd16(-1, v);
        chk(v, ext, "pointer after reset");
        for (int c = 1; c < 4; c++) begin
            rd16(2 * c, v);
            chk(v, rst[c], "reset value");
        end
    endtask

    task automatic sc_addr;
        logic a;
        u_mst.start();
        u_mst.send(8'h42, a);
        u_mst.stop();
        chk({15'h0, a}, 16'h0000, "foreign address acked");
    endtask

    task automatic sc_ro;
        logic [15:0] v;
        wr16(`GPXP_OFS_INPUT0, 16'h1234);
        rd16(0, v);
        chk(v, ext, "input written");
    endtask

    task automatic sc_wr;
        logic [7:0] q [3];
        int nak;
        u_mst.wr(`GPXP_OFS_INVERT1, '{8'hA5, 8'h3C, 8'h81}, 3, nak);
        chk(16'(nak), 16'h0000, "write not acked");
        u_mst.rd(4, 3, q, nak);
        chk({q[1], q[0]}, 16'h813C, "bank toggle");
        chk({8'h00, q[2]}, 16'h003C, "read wrap");
    endtask

    task automatic sc_out;
        logic [15:0] v;
        wr16(`GPXP_OFS_DIR0, 16'h0FF0);
        wr16(`GPXP_OFS_OUTPUT0, 16'hC35A);
        chk(gpio_drv.oe, 16'hF00F, "direction");
        chk(gpio_drv.level & 16'hF00F, 16'hC00A, "drive");
        wr16(`GPXP_OFS_INVERT0, 16'h00FF);
        rd16(0, v);
        chk(v, (16'hC00A | (ext & 16'h0FF0)) ^ 16'h00FF, "in");
        chk({15'h0, int_n}, 16'h0001, "int after read");
    endtask

    task automatic sc_irq;
        logic [7:0] q [3];
        logic [15:0] v;
        int nak;
        @(posedge clk_sys);
        ext <= ext ^ 16'h0001;
        repeat (20) @(posedge clk_sys);
        chk({15'h0, int_n}, 16'h0001, "output pin raised int");
        ext <= ext ^ 16'h0010;
        wait_int(1'b0);
        ext <= ext ^ 16'h0010;
        wait_int(1'b1);
        ext <= ext ^ 16'h0110;
        wait_int(1'b0);
        u_mst.rd(0, 1, q, nak);
        chk({15'h0, int_n}, 16'h0000, "int before bank1 read");
        u_mst.rd(1, 1, q, nak);
        wait_int(1'b1);
        fork
            rd16(0, v);
            begin
                repeat (1700) @(posedge clk_sys);
                ext <= ext ^ 16'h0020;
            end
        join
        repeat (20) @(posedge clk_sys);
        chk({15'h0, int_n}, 16'h0000, "int after read");
        rd16(0, v);
        wait_int(1'b1);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        srst = 1'b1;
        ext = 16'h6C93;
        errors = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        sc_reset();
        sc_addr();
        sc_ro();
        sc_wr();
        sc_out();
        sc_irq();
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        $display("BAD %0t run timed out", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
